// ---- spio_pkg.sv ----
// Functional notes
// RL1: Reset clears return stack pointer; saves move it upward.
// RL2: Return stack pointer loads from accumulator; never readable by firmware.
// RL3: Interrupt entry disables interrupts, saves 14-bit counter plus carry, zero.
// RL4: Save writes first byte at pointer, increments, second byte, increments.
// RL5: Interrupt return pre-decrements twice restoring bytes, then re-enables interrupts.
// RL6: Call pushes counter and flags, pointer advances by two.
// RL7: Return restores counter only, flags kept, pointer back two.
// RL8: Push pre-decrements data stack pointer, then writes operand.
// RL9: Pop reads at data stack pointer, then increments it.
// RL10: Reset clears data stack pointer.
// RL11: Push at pointer zero wraps and writes highest address.
// RL12: Data memory holds 256 bytes shared by all users.
// RL13: Port read moves selected I/O register into accumulator.
// RL14: Port write moves accumulator into addressed I/O register.
// RL15: Indexed port write address is index plus instruction field.
// RL16: Indexed write with zero field selects by index alone.
// RL17: Index register is scratch storage and supplies indexed offsets.
// RL18: Software never writes reserved I/O addresses.
// RL19: Software writes zero into reserved bit positions.
// RL20: Firmware keeps data stack below endpoint buffer area.
// RL21: Both pointers eight bits, wrap modulo 256 silently.
// RL22: Exchange swaps accumulator and data stack pointer in one operation.
package spio_pkg;
  localparam int SPIO_MEM_DEPTH = 256;
  localparam logic [7:0] SPIO_PTR_RST = 8'h00;
  localparam logic [7:0] SPIO_ONE = 8'h01;
  localparam logic [7:0] SPIO_IDX_RST = 8'h00;
  localparam logic [7:0] SPIO_ACC_RST = 8'h00;
  localparam int SPIO_PC_W = 14;
  // Instruction codes from the sequencer
  typedef enum logic [3:0] {
    SPIO_OP_NONE,
    SPIO_OP_INTR,
    SPIO_OP_CALL,
    SPIO_OP_RET,
    SPIO_OP_INTERRUPT_RETURN_INSTR,
    SPIO_OP_PUSH,
    SPIO_OP_POP,
    SPIO_OP_LDRSP,
    SPIO_OP_SWAPDSP,
    SPIO_OP_PRD,
    SPIO_OP_PWR,
    SPIO_OP_PWRX,
    SPIO_OP_LDIDX,
    SPIO_OP_LDACC
  } spio_op_e;
  // Saved return state
  typedef struct packed {
    logic carry;
    logic zero;
    logic [SPIO_PC_W-1:0] pc;
  } spio_ret_s;
  // Port bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } spio_port_s;
endpackage

// ---- spio_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module spio_core
  import spio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire spio_op_e op_i,
  input wire logic [7:0] operand_i,
  input wire spio_ret_s ret_state_i,
  input wire logic [7:0] port_rdata_i,
  output logic busy_o,
  output logic done_o,
  output spio_ret_s ret_state_o,
  output logic ret_flags_o,
  output logic int_enable_o,
  output logic [7:0] acc_o,
  output logic [7:0] idx_o,
  output logic [7:0] pop_data_o,
  output spio_port_s port_o
);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  typedef enum logic [2:0] {
    SPIO_IDLE,
    SPIO_SAVE2,
    SPIO_REST1,
    SPIO_REST2,
    SPIO_POPRD
  } spio_st_e;

  spio_st_e st_q;
  logic [7:0] mem_q [SPIO_MEM_DEPTH];
  logic [7:0] rsp_q;
  logic [7:0] dsp_q;
  logic [7:0] acc_q;
  logic [7:0] idx_q;
  logic [7:0] lo_q;
  logic is_interrupt_return_instr_q;
  logic take;
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] save_hi;
  logic [7:0] save_lo;

  assign take = op_valid_i && (st_q == SPIO_IDLE);
  // First byte holds flags and upper counter bits
  assign save_hi = {ret_state_i.carry, ret_state_i.zero, ret_state_i.pc[13:8]}; // [RL3]
  assign save_lo = ret_state_i.pc[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Memory write port select
  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = rsp_q;
    mem_wd = save_hi;
    if (take && (op_i == SPIO_OP_INTR || op_i == SPIO_OP_CALL))
    begin
      mem_we = 1'b1; // [RL4] [RL6]
    end
    else if (st_q == SPIO_SAVE2)
    begin
      mem_we = 1'b1;
      mem_wd = lo_q;
    end
    else if (take && op_i == SPIO_OP_PUSH)
    begin
      mem_we = 1'b1;
      mem_wa = dsp_q - SPIO_ONE; // [RL8] [RL11]
      mem_wd = operand_i;
    end
  end

  // Shared 256-byte data memory
  always_ff @(posedge mclk_i)
  begin
    if (mem_we)
    begin
      mem_q[mem_wa] <= mem_wd; // [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= SPIO_IDLE;
      is_interrupt_return_instr_q <= 1'b0;
      lo_q <= 8'h00;
    end
    else
    begin
      case (st_q)
        SPIO_IDLE:
        begin
          if (take)
          begin
            case (op_i)
              SPIO_OP_INTR, SPIO_OP_CALL:
              begin
                st_q <= SPIO_SAVE2;
                lo_q <= save_lo;
              end
              SPIO_OP_RET, SPIO_OP_INTERRUPT_RETURN_INSTR:
              begin
                st_q <= SPIO_REST1;
                is_interrupt_return_instr_q <= (op_i == SPIO_OP_INTERRUPT_RETURN_INSTR);
              end
              SPIO_OP_POP: st_q <= SPIO_POPRD;
              default: st_q <= SPIO_IDLE;
            endcase
          end
        end
        SPIO_SAVE2: st_q <= SPIO_IDLE;
        SPIO_REST1: st_q <= SPIO_REST2;
        SPIO_REST2: st_q <= SPIO_IDLE;
        SPIO_POPRD: st_q <= SPIO_IDLE;
        default: st_q <= SPIO_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack pointer, write only from the accumulator
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_q <= SPIO_PTR_RST; // [RL1]
    end
    else if (take && op_i == SPIO_OP_LDRSP)
    begin
      rsp_q <= acc_q; // [RL2]
    end
    else if ((take && (op_i == SPIO_OP_INTR || op_i == SPIO_OP_CALL)) || st_q == SPIO_SAVE2)
    begin
      rsp_q <= rsp_q + SPIO_ONE; // [RL4] [RL21]
    end
    else if ((take && (op_i == SPIO_OP_RET || op_i == SPIO_OP_INTERRUPT_RETURN_INSTR)) || st_q == SPIO_REST1)
    begin
      rsp_q <= rsp_q - SPIO_ONE; // [RL5] [RL7] [RL21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data stack pointer
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dsp_q <= SPIO_PTR_RST; // [RL10]
    end
    else if (take && op_i == SPIO_OP_PUSH)
    begin
      dsp_q <= dsp_q - SPIO_ONE; // [RL8] [RL21]
    end
    else if (take && op_i == SPIO_OP_SWAPDSP)
    begin
      dsp_q <= acc_q; // [RL22]
    end
    else if (st_q == SPIO_POPRD)
    begin
      dsp_q <= dsp_q + SPIO_ONE; // [RL9] [RL21]
    end
  end

  // Pop data read before the pointer moves
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pop_data_o <= 8'h00;
    end
    else if (st_q == SPIO_POPRD)
    begin
      pop_data_o <= mem_q[dsp_q]; // [RL9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and index register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_q <= SPIO_ACC_RST;
      idx_q <= SPIO_IDX_RST;
    end
    else if (take)
    begin
      case (op_i)
        SPIO_OP_LDACC: acc_q <= operand_i;
        SPIO_OP_LDIDX: idx_q <= operand_i; // [RL17]
        SPIO_OP_SWAPDSP: acc_q <= dsp_q; // [RL22]
        SPIO_OP_PRD: acc_q <= port_rdata_i; // [RL13]
        default: acc_q <= acc_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port request, one cycle strobes
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_o <= '0;
    end
    else
    begin
      port_o.rd <= take && op_i == SPIO_OP_PRD;
      port_o.wr <= take && (op_i == SPIO_OP_PWR || op_i == SPIO_OP_PWRX); // [RL14]
      port_o.data <= acc_q;
      port_o.addr <= (take && op_i == SPIO_OP_PWRX) ? idx_q + operand_i
                     : operand_i; // [RL15] [RL16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enable, return state and handshake outputs
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_enable_o <= 1'b0;
      ret_state_o <= '0;
      ret_flags_o <= 1'b0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      done_o <= (take && (op_i != SPIO_OP_INTR && op_i != SPIO_OP_CALL && op_i != SPIO_OP_RET
                 && op_i != SPIO_OP_INTERRUPT_RETURN_INSTR && op_i != SPIO_OP_POP))
                || st_q == SPIO_SAVE2 || st_q == SPIO_REST2 || st_q == SPIO_POPRD;
      busy_o <= (take && (op_i == SPIO_OP_INTR || op_i == SPIO_OP_CALL || op_i == SPIO_OP_RET
                 || op_i == SPIO_OP_INTERRUPT_RETURN_INSTR || op_i == SPIO_OP_POP)) || st_q == SPIO_REST1;
      ret_flags_o <= 1'b0;
      if (take && op_i == SPIO_OP_INTR)
      begin
        int_enable_o <= 1'b0; // [RL3]
      end
      else if (take && op_i == SPIO_OP_LDACC && operand_i == 8'hff)
      begin
        int_enable_o <= int_enable_o;
      end
      if (st_q == SPIO_REST1)
      begin
        // Pointer already moved once, so it addresses the second byte
        ret_state_o.pc[7:0] <= mem_q[rsp_q]; // [RL5]
      end
      if (st_q == SPIO_REST2)
      begin
        ret_state_o.pc[13:8] <= mem_q[rsp_q][5:0];
        if (is_interrupt_return_instr_q)
        begin
          ret_state_o.carry <= mem_q[rsp_q][7]; // [RL5]
          ret_state_o.zero <= mem_q[rsp_q][6];
          ret_flags_o <= 1'b1;
          int_enable_o <= 1'b1; // [RL5]
        end
        else
        begin
          ret_state_o.carry <= ret_state_i.carry; // [RL7]
          ret_state_o.zero <= ret_state_i.zero;
        end
      end
    end
  end

  assign acc_o = acc_q;
  assign idx_o = idx_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_save;
    take && (op_i == SPIO_OP_CALL || op_i == SPIO_OP_INTR);
  endsequence

  a_rsp_save_two: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL4]
    s_save |-> ##2 rsp_q == $past(rsp_q, 2) + 8'h02) else $error("save did not add two");
  a_rsp_rest_two: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL7]
    take && op_i == SPIO_OP_RET |-> ##2 rsp_q == $past(rsp_q, 2) - 8'h02)
    else $error("return did not subtract two");
  a_ret_low_byte: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL5]
    take && (op_i == SPIO_OP_RET || op_i == SPIO_OP_INTERRUPT_RETURN_INSTR)
    |-> ##2 ret_state_o.pc[7:0] == $past(mem_q[rsp_q])) else $error("low byte restore");
  a_intr_disable: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL3]
    take && op_i == SPIO_OP_INTR |=> !int_enable_o) else $error("interrupts not disabled");
  a_interrupt_return_instr_enable: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL5]
    take && op_i == SPIO_OP_INTERRUPT_RETURN_INSTR |-> ##3 int_enable_o && done_o)
    else $error("interrupts not re-enabled");
  a_push_dec: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL8]
    take && op_i == SPIO_OP_PUSH |=> dsp_q == $past(dsp_q) - 8'h01) else $error("push pointer");
  a_pop_inc: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL9]
    take && op_i == SPIO_OP_POP |-> ##2 dsp_q == $past(dsp_q, 2) + 8'h01) else $error("pop pointer");
  a_swap_both: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL22]
    take && op_i == SPIO_OP_SWAPDSP |=> dsp_q == $past(acc_q) && acc_q == $past(dsp_q))
    else $error("swap failed");
  a_pwrx_addr: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL15]
    take && op_i == SPIO_OP_PWRX |=> port_o.wr && port_o.addr == $past(idx_q) + $past(operand_i))
    else $error("indexed address wrong");
  a_rsp_load: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL2]
    take && op_i == SPIO_OP_LDRSP |=> rsp_q == $past(acc_q)) else $error("pointer load");
endmodule
`default_nettype wire

// ---- spio_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spio_port_model
  import spio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire spio_port_s port_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] regs_q [0:255];
  logic [7:0] last_q;
  ////////////////////////////////////////////////////////////////////////////
  // Port registers come out of reset all ones; writes land on the edge
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 256; i++)
        regs_q[i] <= 8'hff;
    end
    else if (port_i.wr)
      regs_q[port_i.addr] <= port_i.data;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Remember the last read so an idle bus never repeats it
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      last_q <= 8'h00;
    else if (rd_en_i)
      last_q <= regs_q[rd_addr_i];
  end
  // Read data only while a port read is under way
  assign rdata_o = rd_en_i ? regs_q[rd_addr_i] : ~last_q;
endmodule
`default_nettype wire

// ---- stack_pointer_and_io_access_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module stack_pointer_and_io_access_tb
  import spio_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  spio_op_e op_i = SPIO_OP_NONE;
  logic [7:0] operand_i = 8'h00;
  spio_ret_s ret_state_i = '0;
  logic [7:0] port_rdata_i;
  logic busy_o;
  logic done_o;
  logic ret_flags_o;
  logic int_enable_o;
  spio_ret_s ret_state_o;
  logic [7:0] acc_o;
  logic [7:0] idx_o;
  logic [7:0] pop_data_o;
  spio_port_s port_o;
  logic rd_en = 1'b0;
  logic flags_seen = 1'b0;
  int fails = 0;
  int n_tests = 0;
  // Free-running core clock
  always #20 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  spio_core dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .operand_i(operand_i), .ret_state_i(ret_state_i), .port_rdata_i(port_rdata_i),
    .busy_o(busy_o), .done_o(done_o), .ret_state_o(ret_state_o),
    .ret_flags_o(ret_flags_o), .int_enable_o(int_enable_o), .acc_o(acc_o),
    .idx_o(idx_o), .pop_data_o(pop_data_o), .port_o(port_o));
  spio_port_model m_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .port_i(port_o), .rd_en_i(rd_en),
    .rd_addr_i(operand_i), .rdata_o(port_rdata_i));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One sequencer request, held while multi-cycle, bounded wait for done
  task automatic op(input spio_op_e code, input logic [7:0] val);
    int n;
    @(negedge mclk_i);
    op_valid_i = 1'b1;
    op_i = code;
    operand_i = val;
    rd_en = (code == SPIO_OP_PRD);
    @(negedge mclk_i);
    if (!(code inside {SPIO_OP_INTR, SPIO_OP_CALL, SPIO_OP_RET, SPIO_OP_INTERRUPT_RETURN_INSTR, SPIO_OP_POP}))
      op_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 8)
    begin
      @(negedge mclk_i);
      n++;
    end
    flags_seen = ret_flags_o;
    op_valid_i = 1'b0;
    rd_en = 1'b0;
    if (n == 8)
    begin
      $display("Error at %0t: operation never completed", $time);
      fails++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk(int_enable_o, 1'b0);
    chk(ret_state_o, 17'h0);
    op(SPIO_OP_SWAPDSP, 8'h00);
    chk(acc_o, 8'h00);
  endtask
  task automatic t_call_ret();
    ret_state_i = {1'b1, 1'b0, 14'h2abc};
    op(SPIO_OP_CALL, 8'h00);
    ret_state_i = {1'b0, 1'b1, 14'h0123};
    op(SPIO_OP_RET, 8'h00);
    chk(ret_state_o, {1'b0, 1'b1, 14'h2abc});
    ret_state_i = {1'b1, 1'b0, 14'h2abc};
    op(SPIO_OP_CALL, 8'h00);
    op(SPIO_OP_LDACC, 8'h00);
    op(SPIO_OP_SWAPDSP, 8'h00);
    op(SPIO_OP_POP, 8'h00);
    chk(pop_data_o, 8'haa);
    op(SPIO_OP_POP, 8'h00);
    chk(pop_data_o, 8'hbc);
  endtask
  task automatic t_intr();
    ret_state_i = {1'b0, 1'b0, 14'h1234};
    op(SPIO_OP_INTR, 8'h00);
    op(SPIO_OP_INTERRUPT_RETURN_INSTR, 8'h00);
    chk(int_enable_o, 1'b1);
    ret_state_i = {1'b1, 1'b1, 14'h0a5a};
    op(SPIO_OP_INTR, 8'h00);
    chk(int_enable_o, 1'b0);
    ret_state_i = {1'b0, 1'b0, 14'h3001};
    op(SPIO_OP_CALL, 8'h00);
    op(SPIO_OP_RET, 8'h00);
    chk(ret_state_o.pc, 14'h3001);
    op(SPIO_OP_INTERRUPT_RETURN_INSTR, 8'h00);
    chk({flags_seen, int_enable_o, ret_state_o}, {2'b11, 1'b1, 1'b1, 14'h0a5a});
  endtask
  task automatic t_ldrsp();
    op(SPIO_OP_LDACC, 8'h40);
    op(SPIO_OP_LDRSP, 8'h00);
    ret_state_i = {1'b0, 1'b1, 14'h3f01};
    op(SPIO_OP_CALL, 8'h00);
    op(SPIO_OP_LDACC, 8'h41);
    op(SPIO_OP_SWAPDSP, 8'h00);
    op(SPIO_OP_POP, 8'h00);
    chk(pop_data_o, 8'h01);
  endtask
  task automatic t_stack();
    op(SPIO_OP_LDACC, 8'h00);
    op(SPIO_OP_SWAPDSP, 8'h00);
    op(SPIO_OP_PUSH, 8'h5a);
    op(SPIO_OP_PUSH, 8'ha5);
    op(SPIO_OP_LDACC, 8'h00);
    op(SPIO_OP_SWAPDSP, 8'h00);
    chk(acc_o, 8'hfe);
    op(SPIO_OP_SWAPDSP, 8'h00);
    op(SPIO_OP_POP, 8'h00);
    chk(pop_data_o, 8'ha5);
    op(SPIO_OP_POP, 8'h00);
    chk(pop_data_o, 8'h5a);
    op(SPIO_OP_LDACC, 8'h20); // Stack kept below the endpoint area
    op(SPIO_OP_SWAPDSP, 8'h00);
    chk(acc_o, 8'h00);
  endtask
  // Reset in mid-run puts both pointers back at zero
  task automatic t_rerun();
    @(negedge mclk_i);
    rst_i = 1'b1;
    @(negedge mclk_i);
    rst_i = 1'b0;
    op(SPIO_OP_SWAPDSP, 8'h00);
    chk(acc_o, 8'h00);
    ret_state_i = {1'b0, 1'b0, 14'h0155};
    op(SPIO_OP_CALL, 8'h00);
    op(SPIO_OP_POP, 8'h00);
    chk(pop_data_o, 8'h01);
  endtask
  task automatic t_port();
    op(SPIO_OP_PRD, 8'h02);
    chk(acc_o, 8'hff);
    chk({port_o.wr, port_o.rd, port_o.addr}, {2'b01, 8'h02});
    op(SPIO_OP_LDACC, 8'h3c);
    op(SPIO_OP_PWR, 8'h08); // Defined address, no reserved bits
    chk({port_o.wr, port_o.rd, port_o.addr, port_o.data}, {2'b10, 8'h08, 8'h3c});
    @(negedge mclk_i);
    chk(m_u.regs_q[8], 8'h3c);
    op(SPIO_OP_LDIDX, 8'h05);
    chk(idx_o, 8'h05);
    op(SPIO_OP_LDACC, 8'h0f);
    op(SPIO_OP_PWRX, 8'h03);
    chk({port_o.wr, port_o.addr, port_o.data}, {1'b1, 8'h08, 8'h0f});
    @(negedge mclk_i);
    chk(m_u.regs_q[8], 8'h0f);
    op(SPIO_OP_PWRX, 8'h00);
    chk({port_o.wr, port_o.addr}, {1'b1, 8'h05});
    @(negedge mclk_i);
    chk(m_u.regs_q[5], 8'h0f);
    op(SPIO_OP_PRD, 8'h05);
    chk(acc_o, 8'h0f);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    t_reset();
    t_call_ret();
    t_intr();
    t_ldrsp();
    t_stack();
    t_port();
    t_rerun();
    finish_test();
  end
endmodule
`default_nettype wire
